// ==== seq_regs.vh ====
// register map, field positions, codes and reset values of the sequence front end
`ifndef SEQ_REGS_VH
`define SEQ_REGS_VH

// ==========================================================
// register byte offsets
`define REG_CTRL        8'h00
`define REG_CMD         8'h04
`define REG_LINE_DATA   8'h08
`define REG_STATUS      8'h0c
`define REG_RESULT      8'h10
`define REG_RUN         8'h14
`define REG_IRQ_STAT    8'h18
`define REG_IRQ_MASK    8'h1c
`define REG_HELP        8'h20
`define REG_LIST        8'h24

// ==========================================================
// control fields
`define CTRL_EDGE_BIT   0
`define CTRL_HOLD_LSB   1
`define CTRL_REL_LSB    4
`define CTRL_RESET      7'h00

// command fields
`define CMD_CHAR_LSB    0
`define CMD_LINE_LSB    8
`define CMD_SEQ_LSB     16

// ==========================================================
// command characters
`define CH_EDIT         8'h45
`define CH_RUN          8'h52
`define CH_ALTER        8'h41
`define CH_DELETE       8'h44
`define CH_INSERT       8'h49
`define CH_CUT          8'h58
`define CH_PASTE        8'h50
`define CH_COPY         8'h43
`define CH_SAVE         8'h53
`define CH_QUIT         8'h51
`define CH_HELP         8'h48
`define CH_LIST         8'h4c
`define CH_MEM          8'h4d
`define HELP_LIST       11'h7ff

// ==========================================================
// interrupt bits
`define IRQ_LAUNCH      0
`define IRQ_ABORT       1
`define IRQ_SAVE        2
`define IRQ_SYNTAX      3
`define IRQ_BADCMD      4
`define IRQ_DONE        5
`define IRQ_W           6
`define IRQ_MASK_RESET  6'h00

// syntax error kinds
`define ERR_NONE        4'h0
`define ERR_EMPTY       4'h1
`define ERR_OPCODE      4'h2
`define OPCODE_BAD      4'hf

`endif

// ==== in_sync.v ====
// two flip-flop synchroniser for a group of pin inputs
`timescale 1ns/10ps
module in_sync #(
  parameter W = 8
) (
  input  wire         clock,
  input  wire         rst_b,
  input  wire [W-1:0] pin_in,
  output wire [W-1:0] sync_out
);

  reg [W-1:0] meta_ff;
  reg [W-1:0] sync_ff;

  // ==========================================================
  // first stage feeds only the second
  always @(posedge clock) begin
    if (!rst_b) begin
      meta_ff <= {W{1'b0}};
      sync_ff <= {W{1'b0}};
    end else begin
      meta_ff <= pin_in;
      sync_ff <= meta_ff;
    end
  end

  assign sync_out = sync_ff;

endmodule

// ==== line_mem.v ====
// edit buffer: one entry per sequence line, registered read data
`timescale 1ns/10ps
module line_mem #(
  parameter AW = 6,
  parameter DW = 16
) (
  input  wire          clock,
  input  wire          we,
  input  wire [AW-1:0] waddr,
  input  wire [DW-1:0] wdata,
  input  wire [AW-1:0] raddr,
  output reg  [DW-1:0] rdata
);

  reg [DW-1:0] mem [0:(1<<AW)-1];

  // ==========================================================
  // write and registered read; read of a just-written word sees old data
  always @(posedge clock) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end

endmodule

// ==== seq_front.v ====
// sequence editor, terminal launch and discrete-input launch front end
`timescale 1ns/10ps
`include "seq_regs.vh"

module seq_front #(
  parameter LINE_AW = 6,
  parameter DATA_W  = 16
) (
  input  wire        clock,
  input  wire        rst_b,
  input  wire [7:0]  addr,
  input  wire [31:0] wdata,
  input  wire        wr_stb,
  input  wire        rd_stb,
  output reg  [31:0] rdata,
  input  wire        start_pin,
  input  wire        abort_pin,
  input  wire [5:0]  select_pins,
  input  wire        powerup_seq_valid,
  input  wire [5:0]  powerup_seq_num,
  input  wire        seq_done,
  output reg         seq_launch_ff,
  output reg  [5:0]  launch_seq_ff,
  output reg         seq_abort_ff,
  output reg         store_req_ff,
  output reg  [5:0]  store_seq_ff,
  output reg         irq_ff
);

  localparam S_IDLE  = 4'd0;
  localparam S_UP_RD = 4'd1;
  localparam S_UP_WR = 4'd2;
  localparam S_DN_RD = 4'd3;
  localparam S_DN_WR = 4'd4;
  localparam S_CK_RD = 4'd5;
  localparam S_CK_EV = 4'd6;
  localparam S_PUT   = 4'd7;
  localparam S_LIST  = 4'd8;
  localparam S_LS_RD = 4'd9;
  localparam CW      = LINE_AW + 1;
  localparam [CW-1:0] DEPTH = {1'b1, {LINE_AW{1'b0}}};

  // ==========================================================
  // zero mask for a select input given to another function
  function [5:0] assign_mask;
    input [2:0] asg;
    begin
      assign_mask = 6'h00;
      if (asg >= 3'd1 && asg <= 3'd6) begin
        assign_mask[asg - 3'd1] = 1'b1;
      end
    end
  endfunction

  // ==========================================================
  // state
  reg [6:0]         ctrl_ff;
  reg [DATA_W-1:0]  line_data_ff;
  reg               edit_mode_ff;
  reg [5:0]         edit_seq_ff;
  reg [CW-1:0]      count_ff;
  reg [CW-1:0]      ptr_ff;
  reg [CW-1:0]      target_ff;
  reg               put_ins_ff;
  reg [3:0]         state_ff;
  reg [7:0]         err_line_ff;
  reg [3:0]         err_kind_ff;
  reg               help_ff;
  reg [DATA_W-1:0]  list_ff;
  reg [`IRQ_W-1:0]  irq_stat_ff;
  reg [`IRQ_W-1:0]  irq_mask_ff;
  reg               running_ff;
  reg               start_prev_ff;
  reg               abort_prev_ff;
  reg               por_pend_ff;
  reg               run_req_ff;
  reg [5:0]         run_seq_ff;
  reg [`IRQ_W-1:0]  ev;

  wire [7:0]        sync_in;
  wire [DATA_W-1:0] mem_rdata;
  reg               mem_we;
  reg [LINE_AW-1:0] mem_waddr;
  reg [DATA_W-1:0]  mem_wdata;
  reg [LINE_AW-1:0] mem_raddr;

  wire       cmd_wr   = wr_stb && (addr == `REG_CMD);
  wire [7:0] cmd_ch   = wdata[`CMD_CHAR_LSB +: 8];
  wire [6:0] cmd_line = wdata[`CMD_LINE_LSB +: 7];
  wire [5:0] cmd_seq  = wdata[`CMD_SEQ_LSB +: 6];
  wire       busy     = (state_ff != S_IDLE);
  // line number in range for alter, delete and list
  wire       line_ok  = (cmd_line >= 7'd1) && (cmd_line <= count_ff);

  // ==========================================================
  // pin synchronisers and edge detection on synced levels
  in_sync #(.W(8)) u_sync (
    .clock    (clock),
    .rst_b    (rst_b),
    .pin_in   ({abort_pin, start_pin, select_pins}),
    .sync_out (sync_in)
  );

  wire       start_s  = sync_in[6];
  wire       abort_s  = sync_in[7];
  wire       edge_sel = ctrl_ff[`CTRL_EDGE_BIT];
  wire [5:0] off_mask = assign_mask(ctrl_ff[`CTRL_HOLD_LSB +: 3]) | assign_mask(ctrl_ff[`CTRL_REL_LSB +: 3]);
  wire [5:0] io_seq   = sync_in[5:0] & ~off_mask;
  wire       st_rise  = start_s && !start_prev_ff;
  wire       st_fall  = !start_s && start_prev_ff;
  wire       io_go    = edge_sel ? st_fall : st_rise;
  wire       io_kill  = (edge_sel && st_rise) || (abort_s && !abort_prev_ff);

  // ==========================================================
  // edit buffer
  line_mem #(.AW(LINE_AW), .DW(DATA_W)) u_mem (
    .clock (clock),
    .we    (mem_we),
    .waddr (mem_waddr),
    .wdata (mem_wdata),
    .raddr (mem_raddr),
    .rdata (mem_rdata)
  );

  // memory port steering by editor state
  always @* begin
    mem_we    = 1'b0;
    mem_waddr = ptr_ff[LINE_AW-1:0];
    mem_wdata = mem_rdata;
    mem_raddr = ptr_ff[LINE_AW-1:0];
    case (state_ff)
      S_UP_RD: mem_raddr = ptr_ff[LINE_AW-1:0] - 1'b1;
      S_UP_WR: mem_we = 1'b1;
      S_DN_RD: mem_raddr = ptr_ff[LINE_AW-1:0] + 1'b1;
      S_DN_WR: mem_we = 1'b1;
      S_PUT: begin
        mem_we    = 1'b1;
        mem_waddr = target_ff[LINE_AW-1:0];
        mem_wdata = line_data_ff;
      end
      default: mem_raddr = ptr_ff[LINE_AW-1:0];
    endcase
  end

  // ==========================================================
  // editor command interpreter
  always @(posedge clock) begin
    if (!rst_b) begin
      state_ff     <= S_IDLE;
      edit_mode_ff <= 1'b0;
      edit_seq_ff  <= 6'h00;
      count_ff     <= {CW{1'b0}};
      ptr_ff       <= {CW{1'b0}};
      target_ff    <= {CW{1'b0}};
      put_ins_ff   <= 1'b0;
      err_line_ff  <= 8'h00;
      err_kind_ff  <= `ERR_NONE;
      help_ff      <= 1'b0;
      list_ff      <= {DATA_W{1'b0}};
      store_req_ff <= 1'b0;
      store_seq_ff <= 6'h00;
      run_req_ff   <= 1'b0;
      run_seq_ff   <= 6'h00;
      ev           <= {`IRQ_W{1'b0}};
    end else begin
      store_req_ff <= 1'b0;
      run_req_ff   <= 1'b0;
      ev           <= {`IRQ_W{1'b0}};
      case (state_ff)
        S_IDLE: begin
          if (cmd_wr && !edit_mode_ff) begin
            if (cmd_ch == `CH_EDIT) begin
              edit_mode_ff  <= 1'b1;
              edit_seq_ff   <= cmd_seq;
              count_ff      <= {CW{1'b0}};
              help_ff       <= 1'b0;
              ev[`IRQ_DONE] <= 1'b1;
            end else if (cmd_ch == `CH_RUN) begin
              run_req_ff    <= 1'b1;
              run_seq_ff    <= cmd_seq;
              ev[`IRQ_DONE] <= 1'b1;
            end else begin
              ev[`IRQ_BADCMD] <= 1'b1;
            end
          end else if (cmd_wr) begin
            case (cmd_ch)
              `CH_INSERT: begin
                if (cmd_line >= 7'd1 && cmd_line <= count_ff + 1'b1 && count_ff < DEPTH) begin
                  target_ff  <= cmd_line - 1'b1;
                  ptr_ff     <= count_ff;
                  put_ins_ff <= 1'b1;
                  state_ff   <= (count_ff == cmd_line - 1'b1) ? S_PUT : S_UP_RD;
                end else begin
                  ev[`IRQ_BADCMD] <= 1'b1;
                end
              end
              `CH_ALTER: begin
                if (line_ok) begin
                  target_ff  <= cmd_line - 1'b1;
                  put_ins_ff <= 1'b0;
                  state_ff   <= S_PUT;
                end else begin
                  ev[`IRQ_BADCMD] <= 1'b1;
                end
              end
              `CH_DELETE: begin
                if (!line_ok) begin
                  ev[`IRQ_BADCMD] <= 1'b1;
                end else if (cmd_line == count_ff) begin
                  count_ff      <= count_ff - 1'b1;
                  ev[`IRQ_DONE] <= 1'b1;
                end else begin
                  ptr_ff   <= cmd_line - 1'b1;
                  state_ff <= S_DN_RD;
                end
              end
              `CH_LIST: begin
                if (line_ok) begin
                  ptr_ff   <= cmd_line - 1'b1;
                  state_ff <= S_LS_RD; // registered read needs a cycle first
                end else begin
                  ev[`IRQ_BADCMD] <= 1'b1;
                end
              end
              `CH_SAVE: begin
                // store first, then check what was stored
                store_req_ff <= 1'b1;
                store_seq_ff <= edit_seq_ff;
                err_kind_ff  <= `ERR_NONE;
                err_line_ff  <= 8'h00;
                ptr_ff       <= {CW{1'b0}};
                if (count_ff == {CW{1'b0}}) begin
                  ev[`IRQ_SAVE] <= 1'b1;
                end else begin
                  state_ff <= S_CK_RD;
                end
              end
              `CH_QUIT: begin
                edit_mode_ff  <= 1'b0;
                help_ff       <= 1'b0;
                ev[`IRQ_DONE] <= 1'b1;
              end
              `CH_HELP: begin
                help_ff       <= 1'b1;
                ev[`IRQ_DONE] <= 1'b1;
              end
              // cut, paste, copy and memory status are handled by firmware
              `CH_CUT, `CH_PASTE, `CH_COPY, `CH_MEM: ev[`IRQ_DONE] <= 1'b1;
              default: ev[`IRQ_BADCMD] <= 1'b1;
            endcase
          end
        end
        S_UP_RD: state_ff <= S_UP_WR;
        S_UP_WR: begin
          ptr_ff   <= ptr_ff - 1'b1;
          state_ff <= (ptr_ff - 1'b1 == target_ff) ? S_PUT : S_UP_RD;
        end
        S_DN_RD: state_ff <= S_DN_WR;
        S_DN_WR: begin
          ptr_ff <= ptr_ff + 1'b1;
          if (ptr_ff + 2'd2 == count_ff) begin
            count_ff      <= count_ff - 1'b1;
            ev[`IRQ_DONE] <= 1'b1;
            state_ff      <= S_IDLE;
          end else begin
            state_ff <= S_DN_RD;
          end
        end
        S_PUT: begin
          if (put_ins_ff) begin
            count_ff <= count_ff + 1'b1;
          end
          ev[`IRQ_DONE] <= 1'b1;
          state_ff      <= S_IDLE;
        end
        S_CK_RD: state_ff <= S_CK_EV;
        S_CK_EV: begin
          // stop at the first faulty line
          if (mem_rdata == {DATA_W{1'b0}} || mem_rdata[DATA_W-1 -: 4] == `OPCODE_BAD) begin
            err_line_ff     <= {{(8-CW){1'b0}}, ptr_ff} + 8'h01;
            err_kind_ff     <= (mem_rdata == {DATA_W{1'b0}}) ? `ERR_EMPTY : `ERR_OPCODE;
            ev[`IRQ_SYNTAX] <= 1'b1;
            state_ff        <= S_IDLE;
          end else if (ptr_ff + 1'b1 == count_ff) begin
            ev[`IRQ_SAVE] <= 1'b1;
            state_ff      <= S_IDLE;
          end else begin
            ptr_ff   <= ptr_ff + 1'b1;
            state_ff <= S_CK_RD;
          end
        end
        S_LIST: begin
          list_ff       <= mem_rdata;
          ev[`IRQ_DONE] <= 1'b1;
          state_ff      <= S_IDLE;
        end
        S_LS_RD: state_ff <= S_LIST;
        default: state_ff <= S_IDLE;
      endcase
      // commands while busy are refused and flagged; idle never sees busy
      if (cmd_wr && busy) begin
        ev[`IRQ_BADCMD] <= 1'b1;
      end
    end
  end

  // ==========================================================
  // launch and abort; abort wins over a launch in the same cycle
  always @(posedge clock) begin
    if (!rst_b) begin
      start_prev_ff <= 1'b0;
      abort_prev_ff <= 1'b0;
      por_pend_ff   <= 1'b1;
      running_ff    <= 1'b0;
      seq_launch_ff <= 1'b0;
      seq_abort_ff  <= 1'b0;
      launch_seq_ff <= 6'h00;
    end else begin
      start_prev_ff <= start_s;
      abort_prev_ff <= abort_s;
      por_pend_ff   <= 1'b0;
      seq_launch_ff <= 1'b0;
      seq_abort_ff  <= 1'b0;
      if (io_kill) begin
        seq_abort_ff <= 1'b1;
        running_ff   <= 1'b0;
      end else if (io_go) begin
        seq_launch_ff <= 1'b1;
        launch_seq_ff <= io_seq;
        running_ff    <= 1'b1;
      end else if (run_req_ff) begin
        seq_launch_ff <= 1'b1;
        launch_seq_ff <= run_seq_ff;
        running_ff    <= 1'b1;
      end else if (por_pend_ff && powerup_seq_valid) begin
        // straps sampled after reset release, not under it
        seq_launch_ff <= 1'b1;
        launch_seq_ff <= powerup_seq_num;
        running_ff    <= 1'b1;
      end else if (seq_done) begin
        running_ff <= 1'b0;
      end
    end
  end

  // ==========================================================
  // register writes, sticky status with set over clear
  always @(posedge clock) begin
    if (!rst_b) begin
      ctrl_ff      <= `CTRL_RESET;
      line_data_ff <= {DATA_W{1'b0}};
      irq_stat_ff  <= {`IRQ_W{1'b0}};
      irq_mask_ff  <= `IRQ_MASK_RESET;
      irq_ff       <= 1'b0;
    end else begin
      if (wr_stb && addr == `REG_CTRL) begin
        ctrl_ff <= wdata[6:0];
      end
      if (wr_stb && addr == `REG_LINE_DATA) begin
        line_data_ff <= wdata[DATA_W-1:0];
      end
      if (wr_stb && addr == `REG_IRQ_MASK) begin
        irq_mask_ff <= wdata[`IRQ_W-1:0];
      end
      irq_stat_ff <= (irq_stat_ff & ~((wr_stb && addr == `REG_IRQ_STAT) ? wdata[`IRQ_W-1:0] : {`IRQ_W{1'b0}}))
                     | ev | {4'h0, seq_abort_ff, seq_launch_ff};
      irq_ff      <= |(irq_stat_ff & irq_mask_ff);
    end
  end

  // ==========================================================
  // read data one cycle after the strobe; unmapped reads zero
  always @(posedge clock) begin
    if (!rst_b) begin
      rdata <= 32'h0000_0000;
    end else if (rd_stb) begin
      case (addr)
        `REG_CTRL:      rdata <= {25'h0, ctrl_ff};
        `REG_LINE_DATA: rdata <= {{(32-DATA_W){1'b0}}, line_data_ff};
        `REG_STATUS:    rdata <= {16'h0, {(8-CW){1'b0}}, count_ff, edit_seq_ff, busy, edit_mode_ff};
        `REG_RESULT:    rdata <= {20'h0, err_kind_ff, err_line_ff};
        `REG_RUN:       rdata <= {25'h0, launch_seq_ff, running_ff};
        `REG_IRQ_STAT:  rdata <= {{(32-`IRQ_W){1'b0}}, irq_stat_ff};
        `REG_IRQ_MASK:  rdata <= {{(32-`IRQ_W){1'b0}}, irq_mask_ff};
        `REG_HELP:      rdata <= help_ff ? {21'h0, `HELP_LIST} : 32'h0000_0000;
        `REG_LIST:      rdata <= {{(32-DATA_W){1'b0}}, list_ff};
        default:        rdata <= 32'h0000_0000;
      endcase
    end else begin
      rdata <= 32'h0000_0000;
    end
  end

endmodule

// ==== seq_front_assertions.sv ====
// port-level assertion checker for the sequence front end
`timescale 1ns/10ps
`include "seq_regs.vh"
module seq_front_checker (
  input wire        clock,
  input wire        rst_b,
  input wire [7:0]  addr,
  input wire [31:0] wdata,
  input wire        wr_stb,
  input wire        abort_pin,
  input wire        powerup_seq_valid,
  input wire [5:0]  powerup_seq_num,
  input wire        seq_launch_ff,
  input wire [5:0]  launch_seq_ff,
  input wire        seq_abort_ff,
  input wire        store_req_ff
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);
  reg [5:0] run_num_ff;
  // ==========================================================
  // helper: number named by the last run command
  always @(posedge clock) begin
    if (wr_stb && addr == `REG_CMD && wdata[7:0] == `CH_RUN)
      run_num_ff <= wdata[21:16];
  end
  // ==========================================================
  // properties
  property p_launch_pulse; seq_launch_ff |=> !seq_launch_ff; endproperty
  a_launch_pulse: assert property (p_launch_pulse) else $error("launch longer than one cycle");
  property p_abort_pulse; seq_abort_ff |=> !seq_abort_ff; endproperty
  a_abort_pulse: assert property (p_abort_pulse) else $error("abort longer than one cycle");
  property p_store_pulse; store_req_ff |=> !store_req_ff; endproperty
  a_store_pulse: assert property (p_store_pulse) else $error("store longer than one cycle");
  property p_store_after_save;
    store_req_ff |-> $past(wr_stb && addr == `REG_CMD && wdata[7:0] == `CH_SAVE);
  endproperty
  a_store_after_save: assert property (p_store_after_save) else $error("store without save");
  property p_run_num;
    wr_stb && addr == `REG_CMD && wdata[7:0] == `CH_RUN |-> ##[1:3] (seq_launch_ff && launch_seq_ff == run_num_ff);
  endproperty
  a_run_num: assert property (p_run_num) else $error("run command did not launch");
  property p_powerup;
    !$past(rst_b) && powerup_seq_valid |=> seq_launch_ff && launch_seq_ff == $past(powerup_seq_num);
  endproperty
  a_powerup: assert property (p_powerup) else $error("power-up sequence not launched");
  property p_abort_pin; $rose(abort_pin) |-> ##[2:8] seq_abort_ff; endproperty
  a_abort_pin: assert property (p_abort_pin) else $error("abort pin ignored");
  property p_launch_hold; !seq_launch_ff |-> $stable(launch_seq_ff); endproperty
  a_launch_hold: assert property (p_launch_hold) else $error("launch number moved");
  c_launch: cover property (seq_launch_ff);
  c_abort: cover property (seq_abort_ff);
  c_store: cover property (store_req_ff);
endmodule
bind seq_front seq_front_checker chk (.clock(clock), .rst_b(rst_b), .addr(addr), .wdata(wdata),
  .wr_stb(wr_stb), .abort_pin(abort_pin), .powerup_seq_valid(powerup_seq_valid),
  .powerup_seq_num(powerup_seq_num), .seq_launch_ff(seq_launch_ff), .launch_seq_ff(launch_seq_ff),
  .seq_abort_ff(seq_abort_ff), .store_req_ff(store_req_ff));

// ==== io_ctrl_model.sv ====
// external controller model driving the discrete launch inputs
`timescale 1ns/10ps
module io_ctrl_model (
  input wire        clock,
  input wire        seq_launch_ff,
  output reg        start_pin,
  output reg        abort_pin,
  output reg  [5:0] select_pins,
  output reg        seq_done
);
  reg [3:0] run_cnt_ff;
  initial begin
    start_pin = 1'b0;
    abort_pin = 1'b0;
    select_pins = 6'h00;
    seq_done = 1'b0;
    run_cnt_ff = 4'h0;
  end
  // ==========================================================
  // a launched sequence finishes a few cycles later
  always @(posedge clock) begin
    run_cnt_ff <= seq_launch_ff ? 4'h4 : (run_cnt_ff != 4'h0 ? run_cnt_ff - 4'h1 : 4'h0);
    seq_done <= (run_cnt_ff == 4'h1);
  end
  // select settles well ahead of the start change, held long after
  task drive_start(input [5:0] sel, input lvl);
    begin
      @(posedge clock) select_pins <= sel;
      repeat (3) @(posedge clock);
      start_pin <= lvl;
      repeat (12) @(posedge clock);
    end
  endtask
  // the controller stops a run through the abort input
  task abort_run;
    begin
      @(posedge clock) abort_pin <= 1'b1;
      repeat (6) @(posedge clock);
      abort_pin <= 1'b0;
      repeat (6) @(posedge clock);
    end
  endtask
endmodule

// ==== tb_sequence_edit_and_launch.sv ====
// self-checking testbench for the sequence front end
`timescale 1ns/10ps
`include "seq_regs.vh"
module tb_sequence_edit_and_launch;
  reg         clock, rst_b, wr_stb, rd_stb, pv;
  reg  [7:0]  addr, r;
  reg  [31:0] wdata, d;
  reg  [5:0]  pn, sel, st_seq;
  wire [31:0] rdata;
  wire        start_pin, abort_pin, seq_done, seq_launch_ff, seq_abort_ff, store_req_ff, irq_ff;
  wire [5:0]  select_pins, launch_seq_ff, store_seq_ff;
  integer     err_count, compares, n_launch, n_abort, e_launch, e_abort, i, m;
  seq_front uut (.clock(clock), .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
    .rd_stb(rd_stb), .rdata(rdata), .start_pin(start_pin), .abort_pin(abort_pin),
    .select_pins(select_pins), .powerup_seq_valid(pv), .powerup_seq_num(pn), .seq_done(seq_done),
    .seq_launch_ff(seq_launch_ff), .launch_seq_ff(launch_seq_ff), .seq_abort_ff(seq_abort_ff),
    .store_req_ff(store_req_ff), .store_seq_ff(store_seq_ff), .irq_ff(irq_ff));
  io_ctrl_model ctl (.clock(clock), .seq_launch_ff(seq_launch_ff), .start_pin(start_pin),
    .abort_pin(abort_pin), .select_pins(select_pins), .seq_done(seq_done));
  // ==========================================================
  // clock, event counters and watchdog
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  always @(posedge clock) begin
    if (rst_b === 1'b1 && seq_launch_ff === 1'b1) n_launch <= n_launch + 1;
    if (rst_b === 1'b1 && seq_abort_ff === 1'b1) n_abort <= n_abort + 1;
    if (store_req_ff === 1'b1) st_seq <= store_seq_ff;
  end
  initial begin
    #(20000 * 5);
    err_count = err_count + 1;
    print_verdict;
  end
  // ==========================================================
  // helpers
  function [7:0] lfsr(input [7:0] x);
    lfsr = {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
  endfunction
  // inputs given to another function read as zero
  function [5:0] exp_sel(input [5:0] s, input [2:0] hold, input [2:0] rel);
    exp_sel = s & ~((hold != 3'h0) ? (6'h01 << (hold - 3'h1)) : 6'h00)
                & ~((rel != 3'h0) ? (6'h01 << (rel - 3'h1)) : 6'h00);
  endfunction
  task chk(input logic [31:0] got, input logic [31:0] exp);
    begin
      compares = compares + 1;
      if (got !== exp) begin
        err_count = err_count + 1;
        $display("unexpected t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task wr(input [7:0] a, input [31:0] v);
    begin
      @(posedge clock) begin wr_stb <= 1'b1; addr <= a; wdata <= v; end
      @(posedge clock) wr_stb <= 1'b0;
    end
  endtask
  task rd(input [7:0] a, output [31:0] v);
    begin
      @(posedge clock) begin rd_stb <= 1'b1; addr <= a; end
      @(posedge clock) rd_stb <= 1'b0;
      #1 v = rdata;
    end
  endtask
  // one editor character with line and number, then wait until idle
  task cmd(input [7:0] ch, input [6:0] ln, input [5:0] sq);
    integer k;
    begin
      wr(`REG_CMD, {10'h0, sq, 1'b0, ln, ch});
      for (k = 0; k < 100; k = k + 1) begin
        rd(`REG_STATUS, d);
        if (d[1] === 1'b0) break;
      end
      chk(d[1], 1'b0);
    end
  endtask
  task ins(input [6:0] ln, input [15:0] v);
    begin
      wr(`REG_LINE_DATA, {16'h0, v});
      cmd(`CH_INSERT, ln, 6'h0);
    end
  endtask
  task print_verdict;
    begin
      $display("mismatches %0d comparisons %0d", err_count, compares);
      if (err_count == 0 && compares > 0)
        $display("Test passed");
      else
        $display("Test failed");
      $finish;
    end
  endtask
  // ==========================================================
  // main sequence
  initial begin
    err_count = 0; compares = 0; n_launch = 0; n_abort = 0; r = 8'd95;
    rst_b = 1'b0; wr_stb = 1'b0; rd_stb = 1'b0; addr = 8'h0; wdata = 32'h0;
    pv = 1'b1; pn = 6'h2a;
    repeat (2) @(posedge clock);
    rst_b <= 1'b1;
    repeat (5) @(posedge clock);
    chk(n_launch, 1);
    chk(launch_seq_ff, 6'h2a);
    e_launch = 1; e_abort = 0;
    // editor session on sequence 5
    cmd(`CH_EDIT, 7'd0, 6'd5);
    rd(`REG_STATUS, d);
    chk(d[7:0], {6'd5, 2'b01});
    ins(7'd1, 16'h1111);
    ins(7'd2, 16'h3333);
    ins(7'd2, 16'h2222);
    cmd(`CH_LIST, 7'd3, 6'd0);
    rd(`REG_LIST, d);
    chk(d, 32'h3333);
    cmd(`CH_DELETE, 7'd1, 6'd0);
    cmd(`CH_LIST, 7'd1, 6'd0);
    rd(`REG_LIST, d);
    chk(d, 32'h2222);
    rd(`REG_STATUS, d);
    chk(d[14:8], 7'd2);
    wr(`REG_LINE_DATA, 32'h4444);
    cmd(`CH_ALTER, 7'd2, 6'd0);
    cmd(`CH_LIST, 7'd2, 6'd0);
    rd(`REG_LIST, d);
    chk(d, 32'h4444);
    cmd(8'h5a, 7'd0, 6'd0);
    rd(`REG_IRQ_STAT, d);
    chk(d[4], 1'b1);
    cmd(`CH_HELP, 7'd0, 6'd0);
    rd(`REG_HELP, d);
    chk(d, {21'h0, `HELP_LIST});
    wr(`REG_IRQ_STAT, 32'h3f);
    wr(`REG_IRQ_MASK, 32'h04);
    cmd(`CH_SAVE, 7'd0, 6'd0);
    repeat (12) @(posedge clock);
    chk(st_seq, 6'd5);
    rd(`REG_IRQ_STAT, d);
    chk(d[3:2], 2'b01);
    chk(irq_ff, 1'b1);
    wr(`REG_IRQ_STAT, 32'h04);
    repeat (3) @(posedge clock);
    chk(irq_ff, 1'b0);
    ins(7'd2, 16'hf123);
    cmd(`CH_SAVE, 7'd0, 6'd0);
    repeat (12) @(posedge clock);
    rd(`REG_RESULT, d);
    chk(d[11:0], {`ERR_OPCODE, 8'd2});
    cmd(`CH_QUIT, 7'd0, 6'd0);
    rd(`REG_STATUS, d);
    chk(d[0], 1'b0);
    rd(`REG_HELP, d);
    chk(d, 32'h0);
    // terminal run
    cmd(`CH_RUN, 7'd0, 6'h11);
    repeat (6) @(posedge clock);
    e_launch = e_launch + 1;
    chk(n_launch, e_launch);
    chk(launch_seq_ff, 6'h11);
    rd(`REG_RUN, d);
    chk(d[6:0], {6'h11, 1'b0});
    // discrete launch: both edge settings, random selects, one corner
    for (i = 0; i < 10; i = i + 1) begin
      m = (i >= 8) ? 32'h2c : (i % 2);
      wr(`REG_CTRL, m);
      r = lfsr(r);
      sel = (i == 0 || i == 8) ? 6'h3f : r[5:0];
      ctl.drive_start(sel, 1'b1);
      ctl.drive_start(sel, 1'b0);
      if (m[0]) e_abort = e_abort + 1;
      e_launch = e_launch + 1;
      chk(n_launch, e_launch);
      chk(n_abort, e_abort);
      chk(launch_seq_ff, exp_sel(sel, m[3:1], m[6:4]));
    end
    ctl.abort_run;
    e_abort = e_abort + 1;
    chk(n_abort, e_abort);
    print_verdict;
  end
endmodule
